// ==== verilog/rom_page_map.svh ====
// offsets, field positions, widths and reset values of the page window
`ifndef ROM_PAGE_MAP_SVH
`define ROM_PAGE_MAP_SVH

// ----------------------------------------------------------------------------
// cpu address map
// ----------------------------------------------------------------------------
`define PAGE_SEL_ADDR 16'hFFF3
`define COMMON_LO 16'h0000
`define COMMON_HI 16'h7FFF
`define WINDOW_LO 16'h8000
`define WINDOW_HI 16'hBFFF
`define PAGE_SEL_RESET 8'h00
`define PAGE_CODE_MSB 2
`define PAGE_CODE_W 3
`define WINDOW_OFS_W 14
`define COMMON_OFS_W 15
`define FLASH_ADDR_W 17
`define PAGE_COUNT_DEF 6
`define RDATA_NONE 8'h00

// ----------------------------------------------------------------------------
// controller registers on apb (byte addresses)
// ----------------------------------------------------------------------------
`define APB_ACCESS_OFS 12'h000
`define APB_STATUS_OFS 12'h004
`define ACC_ADDR_LSB 0
`define ACC_WDATA_LSB 16
`define ACC_WRITE_BIT 24
`define ACC_FETCH_BIT 25
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_REFUSED_BIT 2
`define ST_INWIN_BIT 3
`define ST_RDATA_LSB 8
`define ST_PAGE_LSB 16

`endif

// ==== verilog/rom_page_pkg.sv ====
// types shared by both ends of the page window link
package rom_page_pkg;

  typedef logic [15:0] cpu_addr_t;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] page_code_t;
  typedef logic [16:0] flash_addr_t;

  typedef enum logic [1:0] {dev_idle, dev_flash, dev_capture, dev_reply} dev_state_e;
  typedef enum logic {cpu_idle, cpu_wait} cpu_state_e;

  typedef struct packed {
    dev_state_e state;
    page_code_t page;
    flash_addr_t flash_addr;
    logic flash_rd;
    byte_t rdata;
  } dev_reg_s;

  typedef struct packed {
    cpu_state_e state;
    logic req;
    logic write;
    logic fetch;
    cpu_addr_t addr;
    byte_t wdata;
    byte_t rdata;
    logic done;
    logic refused;
    logic in_window;
    page_code_t page;
  } cpu_reg_s;

endpackage : rom_page_pkg

// ==== verilog/cpu_mem_if.sv ====
// memory access link between the cpu end and the page window device
`timescale 1ns/1ps
interface cpu_mem_if;
  import rom_page_pkg::*;

  logic req;
  logic write;
  logic fetch;
  cpu_addr_t addr;
  byte_t wdata;
  byte_t rdata;
  logic ack;

  modport dev (input req, input write, input fetch, input addr, input wdata,
    output rdata, output ack);
  modport cpu (output req, output write, output fetch, output addr, output wdata,
    input rdata, input ack);
endinterface : cpu_mem_if

// ==== verilog/page_window_map.sv ====
// combinational translation of a cpu address into a flash address
`timescale 1ns/1ps
`include "rom_page_map.svh"
module page_window_map (
  // cpu side
  input wire rom_page_pkg::cpu_addr_t cpu_addr,
  input wire rom_page_pkg::page_code_t page,
  // decoded result
  output logic in_common,
  output logic in_window,
  output logic is_select,
  output rom_page_pkg::flash_addr_t flash_addr
);
  import rom_page_pkg::*;

  always_comb begin
    in_common = (cpu_addr <= `COMMON_HI);
    in_window = (cpu_addr >= `WINDOW_LO) && (cpu_addr <= `WINDOW_HI);
    is_select = (cpu_addr == `PAGE_SEL_ADDR);
    // page n sits just above the common region at (n + 2) * 16k, so page 0
    // continues the common region without a seam
    if (in_window) begin
      flash_addr = {page_code_t'(page + 3'h2), cpu_addr[`WINDOW_OFS_W-1:0]}; // see RL1 RL6 RL14
    end else begin
      flash_addr = {2'h0, cpu_addr[`COMMON_OFS_W-1:0]}; // see RL16
    end
  end
endmodule : page_window_map

// ==== verilog/rom_page_window_select.sv ====
// device end: page select register and switchable flash window
`timescale 1ns/1ps
`include "rom_page_map.svh"

// ----------------------------------------------------------------------------
// page window device
// ----------------------------------------------------------------------------
// Behaviour
// RL1: window 8000H-BFFFH shows selected flash page
// RL2: parameter gives four or six pages
// RL3: select register 8 bits, cpu read/write
// RL4: register at FFF3H, bits 7-3 zero
// RL5: reset clears select register to zero
// RL6: code n selects page n
// RL7: software writes only existing page codes
// RL8: software changes page from common region only
// RL9: rewrites from window are not guarded
// RL10: new page used right after write
// RL11: no sequential fetch across pages
// RL12: cross-page references go through common region
// RL13: interrupt handlers live in common region
// RL14: 7FFFH-8000H straddle works only on page 0
// RL15: switch page in common, then reference
// RL16: other addresses ignore page, upper bits ignored
module rom_page_window_select #(
  parameter int page_count = `PAGE_COUNT_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // cpu link
  cpu_mem_if.dev bus,
  // flash array port, read data valid the cycle after flash_rd
  output rom_page_pkg::flash_addr_t flash_addr,
  output logic flash_rd,
  input wire rom_page_pkg::byte_t flash_rdata,
  // current selection
  output rom_page_pkg::page_code_t page,
  output logic window_hit
);
  import rom_page_pkg::*;

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  generate
    if (page_count != 4 && page_count != 6) begin : g_bad_count
      $error("page_count must be 4 or 6"); // see RL2
    end
    // the top page has to land inside the flash address space
    if ((page_count + 2) * (1 << `WINDOW_OFS_W) > (1 << `FLASH_ADDR_W)) begin : g_bad_fit
      $error("top page lies beyond the flash address"); // see RL2
    end
  endgenerate

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  dev_reg_s cur;
  dev_reg_s next_cur;

  logic dec_common;
  logic dec_window;
  logic dec_select;
  flash_addr_t dec_flash;
  byte_t sel_image;
  logic acc_sel_wr;
  logic acc_sel_rd;
  logic acc_flash;
  logic acc_other;
  byte_t quick_reply;

  // --------------------------------------------------------------------------
  // address translation
  // --------------------------------------------------------------------------
  // common addresses pass straight through; page n sits at (n + 2) * 16k so
  // page 0 continues the common region without a seam
  // the translator always looks at the live page, so an access that follows a
  // select write by one request already sees the new page
  page_window_map u_map (
    .cpu_addr(bus.addr),
    .page(cur.page),
    .in_common(dec_common),
    .in_window(dec_window),
    .is_select(dec_select),
    .flash_addr(dec_flash)
  );

  // --------------------------------------------------------------------------
  // select register image
  // --------------------------------------------------------------------------
  // upper five bits have no storage and always read back as zero
  assign sel_image = {5'h00, cur.page}; // see RL4

  // --------------------------------------------------------------------------
  // access decode
  // --------------------------------------------------------------------------
  // one-hot view of the request in front of the idle device; a request is
  // only looked at while idle, so a held req is never taken twice
  // fetch is not decoded: a fetch and a data read see the same page
  always_comb begin
    acc_sel_wr = 1'b0;
    acc_sel_rd = 1'b0;
    acc_flash = 1'b0;
    acc_other = 1'b0;
    if (bus.req && (cur.state == dev_idle)) begin
      if (dec_select) begin
        acc_sel_wr = bus.write;
        acc_sel_rd = !bus.write;
      end else if ((dec_common || dec_window) && !bus.write) begin
        acc_flash = 1'b1;
      end else begin
        acc_other = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // reply data
  // --------------------------------------------------------------------------
  // writes and unmapped reads answer with a fixed byte, so the cpu never picks
  // up what an earlier flash read left behind
  always_comb begin
    quick_reply = `RDATA_NONE; // see RL16
    if (acc_sel_rd) begin
      quick_reply = sel_image; // see RL3
    end
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.flash_rd = 1'b0;
    case (cur.state)
      dev_idle: begin
        if (acc_sel_wr) begin
          // only the page code bits are stored; codes the variant lacks
          // are the cpu's to avoid, nothing here traps them
          next_cur.page = bus.wdata[`PAGE_CODE_MSB:0]; // see RL3 RL4 RL16 RL7
        end
        if (acc_flash) begin
          // fetch and data read take the same path through the window
          next_cur.flash_addr = dec_flash; // see RL1 RL6 RL10
          next_cur.flash_rd = 1'b1;
          next_cur.state = dev_flash;
        end
        if (acc_sel_wr || acc_sel_rd || acc_other) begin
          // flash is read only and other addresses belong elsewhere
          next_cur.rdata = quick_reply;
          next_cur.state = dev_reply;
        end
      end
      dev_flash: begin
        next_cur.state = dev_capture;
      end
      dev_capture: begin
        next_cur.rdata = flash_rdata;
        next_cur.state = dev_reply;
      end
      dev_reply: begin
        next_cur.state = dev_idle;
      end
      default: begin
        next_cur.state = dev_idle;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  // a select write issued from inside the window simply takes effect; the
  // cpu then fetches from the new page, which is its own problem
  always_ff @(posedge clk) begin // see RL9
    if (!rst_b) begin
      cur.state <= dev_idle;
      cur.page <= page_code_t'(`PAGE_SEL_RESET); // see RL5
      // flash side comes up quiet so no stray read reaches the array
      cur.flash_addr <= '0;
      cur.flash_rd <= 1'b0;
      cur.rdata <= `RDATA_NONE;
    end else begin
      cur <= next_cur;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  // ack comes straight from the state, so it is one cycle long by construction
  assign bus.ack = (cur.state == dev_reply);
  assign bus.rdata = cur.rdata;
  assign flash_addr = cur.flash_addr;
  assign flash_rd = cur.flash_rd;
  assign page = cur.page;
  // high for the one cycle in which a window access is taken
  assign window_hit = bus.req && dec_window && (cur.state == dev_idle);

endmodule : rom_page_window_select

// ==== verilog/cpu_page_master.sv ====
// cpu end: apb-controlled access engine that keeps the paging discipline
`timescale 1ns/1ps
`include "rom_page_map.svh"
module cpu_page_master #(
  parameter int page_count = `PAGE_COUNT_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to the device
  cpu_mem_if.cpu bus
);
  import rom_page_pkg::*;

  generate
    if (page_count != 4 && page_count != 6) begin : g_bad_count
      $error("page_count must be 4 or 6");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  cpu_reg_s cur;
  cpu_reg_s next_cur;
  logic apb_wr;
  logic start;
  logic mapped;
  cpu_addr_t req_addr;
  byte_t req_wdata;
  logic req_write;
  logic sel_write;
  logic bad_code;
  logic from_window;

  assign mapped = (paddr == `APB_ACCESS_OFS) || (paddr == `APB_STATUS_OFS);
  assign apb_wr = psel && penable && pwrite;
  assign start = apb_wr && (paddr == `APB_ACCESS_OFS) && (cur.state == cpu_idle);
  assign req_addr = pwdata[`ACC_ADDR_LSB +: 16];
  assign req_wdata = pwdata[`ACC_WDATA_LSB +: 8];
  assign req_write = pwdata[`ACC_WRITE_BIT];
  assign sel_write = req_write && (req_addr == `PAGE_SEL_ADDR);
  assign bad_code = (req_wdata[7:3] != 5'h00) ||
    (32'(req_wdata[`PAGE_CODE_MSB:0]) >= page_count); // see RL7
  // page changes are refused while the last fetch came from the window
  assign from_window = cur.in_window; // see RL8 RL12 RL15

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    case (cur.state)
      cpu_idle: begin
        if (start) begin
          next_cur.done = 1'b0;
          if (sel_write && (bad_code || from_window)) begin
            next_cur.refused = 1'b1;
            next_cur.done = 1'b1;
          end else begin
            next_cur.refused = 1'b0;
            next_cur.req = 1'b1;
            next_cur.addr = req_addr;
            next_cur.wdata = req_wdata;
            next_cur.write = req_write;
            next_cur.fetch = pwdata[`ACC_FETCH_BIT] && !req_write;
            next_cur.state = cpu_wait;
          end
        end
      end
      cpu_wait: begin
        if (bus.ack) begin
          next_cur.req = 1'b0;
          next_cur.rdata = bus.rdata;
          next_cur.done = 1'b1;
          next_cur.state = cpu_idle;
          if (cur.fetch) begin
            // handlers and page switching code run from the common region
            next_cur.in_window = (cur.addr >= `WINDOW_LO) && (cur.addr <= `WINDOW_HI); // see RL13
          end
          if (cur.write && (cur.addr == `PAGE_SEL_ADDR)) begin
            next_cur.page = cur.wdata[`PAGE_CODE_MSB:0]; // see RL11
          end
        end
      end
      default: begin
        next_cur.state = cpu_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == `APB_STATUS_OFS) begin
      prdata[`ST_BUSY_BIT] = (cur.state == cpu_wait);
      prdata[`ST_DONE_BIT] = cur.done;
      prdata[`ST_REFUSED_BIT] = cur.refused;
      prdata[`ST_INWIN_BIT] = cur.in_window;
      prdata[`ST_RDATA_LSB +: 8] = cur.rdata;
      prdata[`ST_PAGE_LSB +: 3] = cur.page;
    end else if (paddr == `APB_ACCESS_OFS) begin
      prdata[`ACC_ADDR_LSB +: 16] = cur.addr;
      prdata[`ACC_WDATA_LSB +: 8] = cur.wdata;
      prdata[`ACC_WRITE_BIT] = cur.write;
      prdata[`ACC_FETCH_BIT] = cur.fetch;
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign bus.req = cur.req;
  assign bus.write = cur.write;
  assign bus.fetch = cur.fetch;
  assign bus.addr = cur.addr;
  assign bus.wdata = cur.wdata;

endmodule : cpu_page_master

// ==== sim/rom_page_asserts.sv ====
// link checker for the page window device and cpu end
`timescale 1ns/1ps
// ----------------
// link checker
// ----------------
module rom_page_asserts #(
  parameter int page_count = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link
  input wire logic req,
  input wire logic write,
  input wire logic fetch,
  input wire rom_page_pkg::cpu_addr_t addr,
  input wire rom_page_pkg::byte_t wdata,
  input wire rom_page_pkg::byte_t rdata,
  input wire logic ack
);
  import rom_page_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // flash read: strobe, flash data, then reply
  sequence flash_wait;
    !ack ##1 !ack ##1 ack;
  endsequence
  sequence sel_read;
    $rose(req) && !write && addr == 16'hFFF3;
  endsequence
  a_sel_quick: assert property ($rose(req) && addr == 16'hFFF3 |=> ack)
    else $error("select access not answered next cycle");
  a_flash_three: assert property ($rose(req) && !write && addr <= 16'hBFFF |=> flash_wait)
    else $error("flash read not answered in three cycles");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_req_hold: assert property (req && !ack |=> req && $stable(addr) && $stable(write))
    else $error("request changed before ack");
  a_req_drop: assert property (ack |=> !req)
    else $error("request kept after ack");
  a_sel_upper: assert property (sel_read |=> rdata[7:3] == 5'h00)
    else $error("select upper bits not zero");
  a_high_zero: assert property ($rose(req) && !write && addr >= 16'hC000
    && addr != 16'hFFF3 |=> rdata == 8'h00)
    else $error("high read not zero");
  a_code_legal: assert property ($rose(req) && write && addr == 16'hFFF3
    |-> wdata[7:3] == 5'h00 && wdata[2:0] < page_count)
    else $error("illegal page code sent");
  a_rdata_hold: assert property ($changed(rdata) |-> ack)
    else $error("read data changed without ack");
endmodule : rom_page_asserts

// ==== sim/tb.sv ====
// self-checking bench: cpu end and page device joined by the link
`timescale 1ns/1ps
// ----------------
// testbench
// ----------------
module tb;
  import rom_page_pkg::*;
  localparam int pages = 6;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic flash_rd;
  flash_addr_t flash_addr;
  byte_t flash_rdata = 8'h00;
  page_code_t page;
  int n_errors = 0;
  int checked = 0;
  logic [31:0] st;
  logic err;
  logic [15:0] a;
  logic win_hit;
  int n_hit = 0;
  cpu_mem_if link();
  rom_page_window_select #(.page_count(pages)) rom_page_window_select_i (.clk(clk),
    .rst_b(rst_b), .bus(link), .flash_addr(flash_addr), .flash_rd(flash_rd),
    .flash_rdata(flash_rdata), .page(page), .window_hit(win_hit));
  cpu_page_master #(.page_count(pages)) cpu_page_master_i (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(link));
  rom_page_asserts #(.page_count(pages)) rom_page_asserts_i (.clk(clk), .rst_b(rst_b),
    .req(link.req), .write(link.write), .fetch(link.fetch), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
  function automatic byte_t fl(flash_addr_t f);
    return f[7:0] ^ {f[16:14], 5'h00};
  endfunction : fl
  always #5 clk = ~clk;
  // invalid flash data is inverted so a late sample cannot match by luck
  always @(posedge clk) flash_rdata <= flash_rd ? fl(flash_addr) : ~flash_rdata;
  // every window access is taken in exactly one cycle
  always @(posedge clk) if (win_hit === 1'b1) n_hit <= n_hit + 1;
  task automatic chk_byte(string nm, byte_t e, byte_t g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte
  task automatic apb(logic wr, logic [11:0] ad, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    st = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // post one link access, then poll until idle and done
  task automatic op(logic [15:0] ad, byte_t d, logic wr, logic fe);
    int i;
    apb(1'b1, 12'h000, {6'h00, fe, wr, d, ad});
    i = 0;
    do begin
      apb(1'b0, 12'h004, 32'h0);
      i++;
    end while ((st[0] !== 1'b0 || st[1] !== 1'b1) && i < 40);
    if (st[0] !== 1'b0 || st[1] !== 1'b1) begin
      n_errors++;
      $display("Error link done expected 1 seen %b", st[1]);
    end
  endtask : op
  task automatic end_sim();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk_byte("status", 8'h00, st[7:0]);
    op(16'hFFF3, 8'h00, 1'b0, 1'b0);
    chk_byte("select", 8'h00, st[15:8]);
    for (int p = 0; p < pages; p++) begin
      a = 16'h8000 + 16'(p) * 16'h0BFF;
      op(16'hFFF3, 8'(p), 1'b1, 1'b0);
      chk_byte("page", 8'(p), {5'h00, page});
      op(16'hFFF3, 8'h00, 1'b0, 1'b0);
      chk_byte("select", 8'(p), st[15:8]);
      op(a, 8'h00, 1'b0, 1'b1);
      chk_byte("fetch", fl({3'(p + 2), a[13:0]}), st[15:8]);
      op(a, 8'h00, 1'b0, 1'b0);
      chk_byte("data", fl({3'(p + 2), a[13:0]}), st[15:8]);
      op(16'h7FFF, 8'h00, 1'b0, 1'b1);
      chk_byte("common", fl(17'h07FFF), st[15:8]);
    end
    op(16'hFFF3, 8'hF9, 1'b1, 1'b0);
    chk_byte("refused", 8'h01, {7'h00, st[2]});
    op(16'hFFF3, 8'h06, 1'b1, 1'b0);
    chk_byte("refused", 8'h01, {7'h00, st[2]});
    chk_byte("page", 8'h05, {5'h00, page});
    op(16'h9000, 8'h00, 1'b0, 1'b1);
    op(16'hFFF3, 8'h01, 1'b1, 1'b0);
    chk_byte("refused", 8'h01, {7'h00, st[2]});
    op(16'h0100, 8'h00, 1'b0, 1'b1);
    op(16'hFFF3, 8'h01, 1'b1, 1'b0);
    chk_byte("page", 8'h01, {5'h00, page});
    chk_byte("refused", 8'h00, {7'h00, st[2]});
    op(16'hC000, 8'h00, 1'b0, 1'b0);
    chk_byte("high", 8'h00, st[15:8]);
    op(16'h1000, 8'hAA, 1'b1, 1'b0);
    chk_byte("page", 8'h01, {5'h00, page});
    apb(1'b0, 12'h008, 32'h0);
    chk_byte("pslverr", 8'h01, {7'h00, err});
    // a second reset in mid-run must bring the window back to page 0
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk_byte("page", 8'h00, {5'h00, page});
    op(16'hFFF3, 8'h00, 1'b0, 1'b0);
    chk_byte("select", 8'h00, st[15:8]);
    chk_byte("window_hit", 8'(2 * pages + 1), 8'(n_hit));
    end_sim();
  end
endmodule : tb
